// ==== logic/fault_brake_detect.sv ====
// Purpose: Smart fault and low-level brake detector with APB register
// Assumes: fault_in and brake_pin are synchronous to core_clk
// Notes:   Zero-wait APB slave, read data captured in the setup cycle
//
// Function
// - Compare select picks threshold 4/16/64/128
// - Rate select samples at divide 4/8/16/128
// - Enable low disables fault detector, clears counter
// - Read-only bit shows counter active
// - Read-only bit shows counting direction
// - Brake enable bit arms low-level brake detector
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module fault_brake_detect
   import fault_brake_pkg::*;
#(
   parameter int CW = CNT_W
)(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault and brake inputs
   input wire logic fault_in,
   input wire logic brake_pin,
   // Detector outputs
   output logic fault_trip,
   output logic brake_detect
);

   fault_cfg_t cfg_ff;
   fault_cfg_t nxt_cfg;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic brake_ff;
   logic nxt_brake;
   logic [CW-1:0] count_w;
   fault_stat_t stat_w;
   logic tick_w;

   // Register fields at their reset values
   localparam fault_cfg_t CFG_RST = '{
      cmp_sel: FSC_RESET[CMP_LSB+1:CMP_LSB],
      rate_sel: FSC_RESET[RATE_LSB+1:RATE_LSB],
      enable: FSC_RESET[EN_BIT],
      llb_en: FSC_RESET[LLB_BIT]
   };

   // Bus decode
   wire logic hit_w;
   wire logic setup_w;
   wire logic access_w;
   wire logic wr_w;
   wire logic [7:0] reg_rd_w;
   wire logic [CW-1:0] limit_w;

   assign hit_w = (paddr == FSC_ADDR);
   assign setup_w = psel && !penable;
   assign access_w = psel && penable;
   // Only the low byte lane carries register bits
   assign wr_w = access_w && pwrite && hit_w && pstrb[0];

   assign pready = access_w;
   assign pslverr = access_w && !hit_w;
   assign prdata = prdata_ff;

   // Read view of the control word
   assign reg_rd_w[CMP_LSB+1:CMP_LSB] = cfg_ff.cmp_sel;
   assign reg_rd_w[RATE_LSB+1:RATE_LSB] = cfg_ff.rate_sel;
   assign reg_rd_w[EN_BIT] = cfg_ff.enable;
   assign reg_rd_w[ACT_BIT] = stat_w.active;
   assign reg_rd_w[DIR_BIT] = stat_w.up_dir;
   assign reg_rd_w[LLB_BIT] = cfg_ff.llb_en;

   assign nxt_prdata = (setup_w && !pwrite && hit_w) ?
                       {24'h000000, reg_rd_w} : 32'h00000000;

   // Status bits are not writable; only the four control fields load
   assign nxt_cfg = wr_w ? fault_cfg_t'{
      cmp_sel: pwdata[CMP_LSB+1:CMP_LSB],
      rate_sel: pwdata[RATE_LSB+1:RATE_LSB],
      enable: pwdata[EN_BIT],
      llb_en: pwdata[LLB_BIT]
   } : cfg_ff;

   assign limit_w = (cfg_ff.cmp_sel == 2'h0) ? CMP_VAL0 :
                    (cfg_ff.cmp_sel == 2'h1) ? CMP_VAL1 :
                    (cfg_ff.cmp_sel == 2'h2) ? CMP_VAL2 : CMP_VAL3;

   // Low level on the brake pin counts only while armed
   assign nxt_brake = cfg_ff.llb_en && !brake_pin;

   assign fault_trip = stat_w.tripped;
   assign brake_detect = brake_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_ff <= CFG_RST;
         prdata_ff <= 32'h00000000;
         brake_ff <= 1'b0;
      end else begin
         cfg_ff <= nxt_cfg;
         prdata_ff <= nxt_prdata;
         brake_ff <= nxt_brake;
      end
   end

   fault_sample_tick u_tick (
      .core_clk (core_clk),
      .rst (rst),
      .run (cfg_ff.enable),
      .rate_sel (cfg_ff.rate_sel),
      .tick (tick_w)
   );

   fault_updown_counter #(
      .CW (CW)
   ) u_count (
      .core_clk (core_clk),
      .rst (rst),
      .enable (cfg_ff.enable),
      .tick (tick_w),
      .fault_level (fault_in),
      .limit (limit_w),
      .count (count_w),
      .stat (stat_w)
   );

   // Register access checks

   cfg_write_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_w |=> (cfg_ff.enable == $past(pwdata[EN_BIT])) &&
               (cfg_ff.cmp_sel == $past(pwdata[CMP_LSB+1:CMP_LSB])))
      else $error("control write did not land");

   brake_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.llb_en && !wr_w) |=> cfg_ff.llb_en)
      else $error("brake enable cleared without a write");

   rd_active_a: assert property (@(posedge core_clk) disable iff (rst)
      (setup_w && !pwrite && hit_w) |=>
      prdata[ACT_BIT] == $past(stat_w.active))
      else $error("active bit read back wrong");

   rd_dir_a: assert property (@(posedge core_clk) disable iff (rst)
      (setup_w && !pwrite && hit_w) |=>
      prdata[DIR_BIT] == $past(stat_w.up_dir))
      else $error("direction bit read back wrong");

   unmapped_err_a: assert property (@(posedge core_clk) disable iff (rst)
      (access_w && !hit_w) |-> pslverr && pready && !wr_w)
      else $error("unmapped access not refused");

   rd_idle_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      !(setup_w && !pwrite && hit_w) |=> prdata == 32'h00000000)
      else $error("read data not zero outside a read");

   rd_fields_a: assert property (@(posedge core_clk) disable iff (rst)
      (setup_w && !pwrite && hit_w) |=>
      prdata == {24'h000000, $past({cfg_ff.cmp_sel, cfg_ff.rate_sel,
         cfg_ff.enable, stat_w.active, stat_w.up_dir, cfg_ff.llb_en})})
      else $error("control word read back wrong");

   rate_write_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_w |=> cfg_ff.rate_sel == $past(pwdata[RATE_LSB+1:RATE_LSB]))
      else $error("rate select write did not land");

   llb_write_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_w |=> cfg_ff.llb_en == $past(pwdata[LLB_BIT]))
      else $error("brake enable write did not land");

   cfg_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !wr_w |=> $stable(cfg_ff))
      else $error("control word changed without a write");

   wr_miss_a: assert property (@(posedge core_clk) disable iff (rst)
      (access_w && pwrite && !hit_w) |=> $stable(cfg_ff))
      else $error("write to unmapped address landed");

   // Detector behaviour checks

   limit_map_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.cmp_sel == 2'h3 |-> limit_w == 8'h80) and
      (cfg_ff.cmp_sel == 2'h2 |-> limit_w == 8'h40) and
      (cfg_ff.cmp_sel == 2'h1 |-> limit_w == 8'h10) and
      (cfg_ff.cmp_sel == 2'h0 |-> limit_w == 8'h04))
      else $error("compare threshold mapped wrong");

   disable_clear_a: assert property (@(posedge core_clk)
      disable iff (rst)
      !cfg_ff.enable |=> (count_w == '0) && !stat_w.active && !fault_trip)
      else $error("disabled detector kept its count");

   no_tick_off_a: assert property (@(posedge core_clk)
      disable iff (rst)
      (!cfg_ff.enable) [*2] |-> !tick_w)
      else $error("sample tick while detector disabled");

   active_map_a: assert property (@(posedge core_clk) disable iff (rst)
      stat_w.active == (count_w != '0))
      else $error("active status disagrees with count");

   dir_follow_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.enable) ##1 cfg_ff.enable |->
      stat_w.up_dir == $past(fault_in))
      else $error("direction does not follow sampled input");

   count_down_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.enable && !fault_in && count_w != '0 &&
       count_w <= limit_w) ##1 cfg_ff.enable |->
      count_w == $past(count_w) - 1'b1)
      else $error("counter did not step down on a clean tick");

   trip_reach_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.enable && count_w == limit_w && $stable(limit_w)) |->
      fault_trip)
      else $error("count at compare value but no trip");

   count_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.enable && !tick_w && count_w <= limit_w) ##1
      (cfg_ff.enable && $stable(limit_w)) |-> $stable(count_w))
      else $error("count moved without a sample tick");

   brake_on_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.llb_en && !brake_pin) |=> brake_detect)
      else $error("armed brake detector missed a low level");

   brake_off_a: assert property (@(posedge core_clk) disable iff (rst)
      (!cfg_ff.llb_en || brake_pin) |=> !brake_detect)
      else $error("brake detect without armed low level");

   tick_slow_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.rate_sel == 2'h3) ##1
      (cfg_ff.rate_sel == 2'h3) [*8] |-> !tick_w)
      else $error("divide by 128 ticking too fast");

   // Counting and sample rate checks

   dir_off_a: assert property (@(posedge core_clk) disable iff (rst)
      !cfg_ff.enable |=> !stat_w.up_dir)
      else $error("direction set while detector disabled");

   dir_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.enable && !tick_w) ##1 cfg_ff.enable |->
      $stable(stat_w.up_dir))
      else $error("direction moved without a sample tick");

   trip_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (fault_trip && cfg_ff.enable && !tick_w && $stable(limit_w)) |=>
      fault_trip)
      else $error("trip dropped without a sample tick");

   count_cap_a: assert property (@(posedge core_clk) disable iff (rst)
      $stable(limit_w) |-> count_w <= limit_w)
      else $error("count above the compare value");

   trip_below_a: assert property (@(posedge core_clk) disable iff (rst)
      (count_w < $past(limit_w)) |-> !fault_trip)
      else $error("trip while count under compare value");

   tick_rate1_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.enable && cfg_ff.rate_sel == 2'h1) ##1
      (cfg_ff.enable && cfg_ff.rate_sel == 2'h1) [*8] |-> tick_w)
      else $error("divide by eight tick missing");

   tick_rate2_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.enable && cfg_ff.rate_sel == 2'h2) ##1
      (cfg_ff.enable && cfg_ff.rate_sel == 2'h2) [*8] ##1
      (cfg_ff.enable && cfg_ff.rate_sel == 2'h2) [*8] |-> tick_w)
      else $error("divide by sixteen tick missing");

   tick_en_a: assert property (@(posedge core_clk) disable iff (rst)
      tick_w |-> $past(cfg_ff.enable))
      else $error("sample tick without a prior enable");

   sat_top_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.enable && fault_in && count_w == limit_w) |=>
      count_w == $past(count_w))
      else $error("count passed the compare value");

   sat_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && !fault_in && count_w == '0) |=> count_w == '0)
      else $error("count wrapped below zero");

   clamp_low_a: assert property (@(posedge core_clk) disable iff (rst)
      (cfg_ff.enable && count_w > limit_w) |=> count_w == $past(limit_w))
      else $error("count not pulled down to a lowered limit");

   idle_drop_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick_w && cfg_ff.enable && !fault_in && count_w == CW'(1)) |=>
      !stat_w.active)
      else $error("counter still active after reaching zero");

endmodule

`default_nettype wire

// ==== logic/fault_brake_pkg.sv ====
// Purpose: Shared constants and types of the fault and brake detector
// Assumes: 32-bit APB register access, one 8-bit control word
// Notes:   Register sits at word index C5, byte address four times that
`default_nettype none

package fault_brake_pkg;

   // Register map
   localparam int APB_AW = 12;
   localparam logic [7:0] FSC_INDEX = 8'hC5;
   localparam logic [APB_AW-1:0] FSC_ADDR = {2'h0, FSC_INDEX, 2'h0};
   localparam logic [7:0] FSC_RESET = 8'h00;

   // Field positions of fault_sampling_control
   localparam int CMP_LSB = 6;
   localparam int RATE_LSB = 4;
   localparam int EN_BIT = 3;
   localparam int ACT_BIT = 2;
   localparam int DIR_BIT = 1;
   localparam int LLB_BIT = 0;

   // Compare thresholds by fault_compare_select code
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CMP_VAL0 = 8'h04;
   localparam logic [CNT_W-1:0] CMP_VAL1 = 8'h10;
   localparam logic [CNT_W-1:0] CMP_VAL2 = 8'h40;
   localparam logic [CNT_W-1:0] CMP_VAL3 = 8'h80;

   // Prescaler terminal counts: oscillator_clock divided by 4, 8, 16, 128
   localparam int PRE_W = 7;
   localparam logic [PRE_W-1:0] RATE_LAST0 = 7'h03;
   localparam logic [PRE_W-1:0] RATE_LAST1 = 7'h07;
   localparam logic [PRE_W-1:0] RATE_LAST2 = 7'h0F;
   localparam logic [PRE_W-1:0] RATE_LAST3 = 7'h7F;

   typedef struct packed {
      logic [1:0] cmp_sel;
      logic [1:0] rate_sel;
      logic enable;
      logic llb_en;
   } fault_cfg_t;

   typedef struct packed {
      logic active;
      logic up_dir;
      logic tripped;
   } fault_stat_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_TRIP = 3'b100
   } cnt_state_t;

endpackage

`default_nettype wire

// ==== logic/fault_sample_tick.sv ====
// Purpose: Sample tick prescaler for the fault input
// Assumes: core_clk is the oscillator clock
// Notes:   Tick is one cycle wide, cleared from the cycle after run goes low
`timescale 1ns/1ps
`default_nettype none

module fault_sample_tick
   import fault_brake_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [1:0] rate_sel,
   // Tick out
   output logic tick
);

   logic [PRE_W-1:0] div_ff;
   logic [PRE_W-1:0] nxt_div;
   logic tick_ff;
   wire logic [PRE_W-1:0] last_w;
   wire logic wrap_w;

   assign last_w = (rate_sel == 2'h0) ? RATE_LAST0 :
                   (rate_sel == 2'h1) ? RATE_LAST1 :
                   (rate_sel == 2'h2) ? RATE_LAST2 : RATE_LAST3;
   // A shrinking divisor wraps at once instead of running to 127
   assign wrap_w = run && (div_ff >= last_w);
   assign nxt_div = (!run || wrap_w) ? '0 : div_ff + 7'h01;
   assign tick = tick_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         tick_ff <= wrap_w;
      end
   end

   tick_gap_a: assert property (@(posedge core_clk) disable iff (rst)
      tick |=> !tick [*3])
      else $error("sample ticks closer than four cycles");

   tick_div4_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick && run && rate_sel == 2'h0) ##1
      (run && rate_sel == 2'h0) [*4] |-> tick)
      else $error("divide by four tick missing");

endmodule

`default_nettype wire

// ==== logic/fault_updown_counter.sv ====
// Purpose: Up/down fault counter with compare and trip state
// Assumes: tick is a one-cycle sample strobe
// Notes:   Count saturates at zero and at the selected limit
`timescale 1ns/1ps
`default_nettype none

module fault_updown_counter
   import fault_brake_pkg::*;
#(
   parameter int CW = CNT_W
)(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic enable,
   input wire logic tick,
   input wire logic fault_level,
   input wire logic [CW-1:0] limit,
   // State out
   output logic [CW-1:0] count,
   output fault_stat_t stat
);

   logic [CW-1:0] count_ff;
   logic [CW-1:0] nxt_count;
   logic dir_ff;
   logic nxt_dir;
   cnt_state_t state_ff;
   cnt_state_t nxt_state;
   wire logic up_w;
   wire logic dn_w;

   assign up_w = tick && fault_level && (count_ff < limit);
   assign dn_w = tick && !fault_level && (count_ff != '0);
   // Lowering the limit pulls an oversized count straight down to it
   assign nxt_count = !enable ? '0 :
                      (count_ff > limit) ? limit :
                      up_w ? count_ff + CW'(1) :
                      dn_w ? count_ff - CW'(1) : count_ff;
   assign nxt_dir = !enable ? 1'b0 : tick ? fault_level : dir_ff;
   assign nxt_state = (nxt_count == '0) ? ST_IDLE :
                      (nxt_count >= limit) ? ST_TRIP : ST_RUN;
   assign count = count_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_ff <= '0;
         dir_ff <= 1'b0;
         state_ff <= ST_IDLE;
      end else begin
         count_ff <= nxt_count;
         dir_ff <= nxt_dir;
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      unique case (state_ff)
         ST_IDLE: stat = '{active: 1'b0, up_dir: dir_ff, tripped: 1'b0};
         ST_RUN: stat = '{active: 1'b1, up_dir: dir_ff, tripped: 1'b0};
         ST_TRIP: stat = '{active: 1'b1, up_dir: dir_ff, tripped: 1'b1};
         default: stat = '{active: 1'b0, up_dir: 1'b0, tripped: 1'b0};
      endcase
   end

   count_up_a: assert property (@(posedge core_clk) disable iff (rst)
      (enable && tick && fault_level && count_ff < limit) ##1 enable
      |-> count_ff == $past(count_ff) + 1'b1)
      else $error("counter did not step up on a faulted tick");

   trip_at_limit_a: assert property (@(posedge core_clk)
      disable iff (rst) stat.tripped |-> count_ff >= $past(limit))
      else $error("trip reported below the compare value");

endmodule

`default_nettype wire

// ==== testbench/fault_source.sv ====
// Purpose: Model of the fault line and brake pin outside the device
// Assumes: Requests come from the bench, synchronous to core_clk
// Notes:   One flop of delay stands in for the external input path
`timescale 1ns/1ps
`default_nettype none

module fault_source (
   // Clock
   input wire logic core_clk,
   // Requests from the bench
   input wire logic fault_req,
   input wire logic brake_req,
   // Lines into the device
   output logic fault_in,
   output logic brake_pin
);
   // Brake pin idles high, so it is low only while a brake is asked for
   initial begin
      fault_in = 1'b0;
      brake_pin = 1'b1;
   end

   always @(posedge core_clk) begin
      fault_in <= fault_req;
      brake_pin <= ~brake_req;
   end
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench of the fault and brake detector
// Assumes: Zero-wait APB slave, one control word at FSC_ADDR
// Notes:   Trip time is checked in a window, since tick phase is loose
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import fault_brake_pkg::*;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic fault_in, brake_pin, fault_trip, brake_detect;
   logic fault_req, brake_req;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int meas;
   longint t0;
   localparam logic [APB_AW-1:0] BAD_ADDR = 12'h318;
   localparam int LIM [4] = '{4, 16, 64, 128};
   localparam int DIV [4] = '{4, 8, 16, 128};

   fault_brake_detect #(.CW(CNT_W)) dut_u (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_in(fault_in), .brake_pin(brake_pin),
      .fault_trip(fault_trip), .brake_detect(brake_detect));

   fault_source src_u (.core_clk(core_clk), .fault_req(fault_req),
      .brake_req(brake_req), .fault_in(fault_in), .brake_pin(brake_pin));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Longest run is the slowest trip, about 17000 cycles
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         conclude();
      end
   end

   task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic chk_bit(input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   // One APB transfer; waits for pready without assuming its latency
   task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      fault_req = 1'b0;
      brake_req = 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      apb(1'b0, FSC_ADDR, 32'h0);
      chk_word({24'h0, FSC_RESET}, rd);
      chk_bit(1'b0, err);
      apb(1'b1, BAD_ADDR, 32'hFF);
      chk_bit(1'b1, err);
      apb(1'b0, BAD_ADDR, 32'h0);
      chk_word(32'h0, rd);
      chk_bit(1'b1, err);
      apb(1'b0, FSC_ADDR, 32'h0);
      chk_word(32'h0, rd);
      // Status bits and upper bits must ignore the written ones
      apb(1'b1, FSC_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, FSC_ADDR, 32'h0);
      chk_word(32'h0000_00F9, rd);
      // A write without the low byte strobe must leave the word alone
      pstrb <= 4'hE;
      apb(1'b1, FSC_ADDR, 32'h0);
      pstrb <= 4'hF;
      apb(1'b0, FSC_ADDR, 32'h0);
      chk_word(32'h0000_00F9, rd);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, FSC_ADDR, 32'h0);
         fault_req <= 1'b1;
         apb(1'b1, FSC_ADDR, 32'(k * 8'h50 + 8'h08));
         t0 = $time;
         repeat (DIV[k] * 2 + 4) @(posedge core_clk);
         apb(1'b0, FSC_ADDR, 32'h0);
         chk_word(32'(k * 8'h50 + 8'h0E), rd);
         while (fault_trip !== 1'b1 && cyc < 39000) @(posedge core_clk);
         meas = int'(($time - t0) / 100);
         chk_bit(1'b1, meas >= LIM[k] * DIV[k]);
         chk_bit(1'b1, meas <= LIM[k] * DIV[k] + DIV[k] + 4);
         fault_req <= 1'b0;
         repeat (DIV[k] * 2 + 4) @(posedge core_clk);
         apb(1'b0, FSC_ADDR, 32'h0);
         chk_word(32'(k * 8'h50 + 8'h0C), rd);
         chk_bit(1'b0, fault_trip);
      end
      // Disabling must wipe a nonzero count at once
      apb(1'b1, FSC_ADDR, 32'h0);
      apb(1'b0, FSC_ADDR, 32'h0);
      chk_word(32'h0, rd);
      chk_bit(1'b0, fault_trip);
      brake_req <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk_bit(1'b0, brake_detect);
      apb(1'b1, FSC_ADDR, 32'h01);
      repeat (2) @(posedge core_clk);
      chk_bit(1'b1, brake_detect);
      brake_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk_bit(1'b0, brake_detect);
      apb(1'b0, FSC_ADDR, 32'h0);
      chk_word(32'h01, rd);
      brake_req <= 1'b1;
      apb(1'b1, FSC_ADDR, 32'h0);
      repeat (2) @(posedge core_clk);
      chk_bit(1'b0, brake_detect);
      conclude();
   end
endmodule

`default_nettype wire
